// [mfv_csr.sv]
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Data register returns PHY read word, supplies PHY write word.
// - Pause frame carries 16-bit pause time from flow control register.
// - Pass-pause 0: decode pause frames, filter bit stays cleared.
// - Pass-pause 1: decode pause frames, filter bit set.
// - Enable 0 disables pause decode and back-pressure; 1 pause full, back-pressure half.
// - Writing busy 1 in full duplex sends pause; cleared on done.
// - First tag match on bytes 13-14 allows 1522-byte frames.
// - Second tag match on same bytes allows 1538-byte frames.
// - Four wake filters via one 32-bit window, eight accesses.
// - Global-unicast 0: wake needs address and wake filter pass.
// - Global-unicast 1: wake needs wake filter pass alone.
// - Wake frame flag sets on frame wake, clears on write 1.
// - Pattern flag sets on pattern wake, clears on write 1.
// - Only power-on reset clears the two wake flags.
// - Wake frame enable enters sleep, allows frame wake.
// - Pattern enable enters sleep, allows pattern wake.
// - Management block reaches PHY registers over two-wire bus.
// - Writing management address starts the PHY access.
module mfv_csr #(
    parameter int FILTER_WORDS = 8
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic POR_RST,
    input wire logic CE,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic FULL_DUPLEX,
    output logic PAUSE_REQ,
    output logic [15:0] PAUSE_TIME,
    input wire logic PAUSE_SENT,
    output logic BACK_PRESSURE_EN,
    input wire logic RX_PAUSE_FRAME,
    output logic PAUSE_DECODE_EN,
    output logic RX_PAUSE_FILTER,
    input wire logic [15:0] RX_TAG_FIELD,
    output logic [10:0] MAX_FRAME_LEN,
    output logic MGMT_START,
    output logic MGMT_WRITE,
    output logic [4:0] MGMT_PHY_ADDR,
    output logic [4:0] MGMT_REG_ADDR,
    output logic [15:0] MGMT_WDATA,
    input wire logic MGMT_DONE,
    input wire logic [15:0] MGMT_RDATA,
    input wire logic RX_WAKE_FRAME_MATCH,
    input wire logic RX_ADDR_PASS,
    input wire logic RX_PATTERN_PACKET,
    output logic [31:0] FILTER_WORD,
    output logic [2:0] FILTER_INDEX,
    output logic SLEEP,
    output logic WAKE_EVENT
);
    ////////////////////////////////////////////////////////////////////
    logic ack_r;
    logic req;
    logic wr;
    logic [31:0] wmask;
    logic [31:0] wd;
    logic pause_busy_r;
    logic fc_enable_r;
    logic fc_pass_r;
    logic [15:0] pause_time_r;
    logic [15:0] tag_a_r;
    logic [15:0] tag_b_r;
    logic [15:0] phy_word_r;
    logic mg_write_r;
    logic [4:0] mg_phy_r;
    logic [4:0] mg_reg_r;
    logic mg_start_r;
    mfv_pkg::mfv_mg_state_t mg_state_r;
    logic [31:0] filt_mem [FILTER_WORDS];
    logic [2:0] filt_ptr_r;
    logic [31:0] filt_rd_r;
    logic gu_r;
    logic wf_en_r;
    logic pp_en_r;
    logic wf_flag_r;
    logic pp_flag_r;
    logic wake_r;
    logic frame_wake;
    logic pattern_wake;
    logic [31:0] rdata;

    ////////////////////////////////////////////////////////////////////
    // Bus slave: one wait state, ack dropped the cycle after
    assign req = WB_CYC_I && WB_STB_I && !ack_r;
    assign wr = req && WB_WE_I && CE;
    assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                    {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    assign wd = WB_DAT_I & wmask;

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ack_r <= 1'b0;
        end else if (CE) begin
            ack_r <= req;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            WB_DAT_O <= 32'h0000_0000;
        end else if (CE && req) begin
            WB_DAT_O <= rdata;
        end
    end
    assign WB_ACK_O = ack_r;

    always_comb begin
        rdata = mfv_pkg::UNMAPPED_READ;
        unique case (WB_ADR_I)
            mfv_pkg::MGMT_ADDR_OFS: begin
                rdata[mfv_pkg::MA_PHY_LSB +: 5] = mg_phy_r;
                rdata[mfv_pkg::MA_REG_LSB +: 5] = mg_reg_r;
                rdata[mfv_pkg::MA_WRITE_BIT] = mg_write_r;
                rdata[mfv_pkg::MA_BUSY_BIT] =
                    (mg_state_r != mfv_pkg::MG_IDLE);
            end
            mfv_pkg::PHY_DATA_OFS: rdata[15:0] = phy_word_r;
            mfv_pkg::FLOW_CTRL_OFS: begin
                rdata[mfv_pkg::FC_PAUSE_LSB +: 16] = pause_time_r;
                rdata[mfv_pkg::FC_PASS_BIT] = fc_pass_r;
                rdata[mfv_pkg::FC_ENABLE_BIT] = fc_enable_r;
                rdata[mfv_pkg::FC_BUSY_BIT] = pause_busy_r;
            end
            mfv_pkg::TAG_A_OFS: rdata[15:0] = tag_a_r;
            mfv_pkg::TAG_B_OFS: rdata[15:0] = tag_b_r;
            mfv_pkg::WAKE_PORT_OFS: rdata = filt_rd_r;
            mfv_pkg::WAKE_CTRL_OFS: begin
                rdata[mfv_pkg::WK_GU_BIT] = gu_r;
                rdata[mfv_pkg::WK_WF_FLAG_BIT] = wf_flag_r;
                rdata[mfv_pkg::WK_PP_FLAG_BIT] = pp_flag_r;
                rdata[mfv_pkg::WK_WF_EN_BIT] = wf_en_r;
                rdata[mfv_pkg::WK_PP_EN_BIT] = pp_en_r;
            end
            default: rdata = mfv_pkg::UNMAPPED_READ;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Flow control
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pause_time_r <= 16'h0000;
            fc_pass_r <= 1'b0;
            fc_enable_r <= 1'b0;
        end else if (CE && wr && WB_ADR_I == mfv_pkg::FLOW_CTRL_OFS) begin
            if (WB_SEL_I[3]) begin
                pause_time_r[15:8] <= WB_DAT_I[31:24];
            end
            if (WB_SEL_I[2]) begin
                pause_time_r[7:0] <= WB_DAT_I[23:16];
            end
            if (WB_SEL_I[0]) begin
                fc_pass_r <= WB_DAT_I[mfv_pkg::FC_PASS_BIT];
                fc_enable_r <= WB_DAT_I[mfv_pkg::FC_ENABLE_BIT];
            end
        end
    end

    // Done wins over a new request: software must see busy low first
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pause_busy_r <= 1'b0;
        end else if (CE) begin
            if (pause_busy_r && PAUSE_SENT) begin
                pause_busy_r <= 1'b0;
            end else if (wr && WB_ADR_I == mfv_pkg::FLOW_CTRL_OFS
                         && WB_SEL_I[0] && wd[mfv_pkg::FC_BUSY_BIT]
                         && FULL_DUPLEX) begin
                pause_busy_r <= 1'b1;
            end
        end
    end

    assign PAUSE_REQ = pause_busy_r && FULL_DUPLEX;
    assign PAUSE_TIME = pause_time_r;
    assign BACK_PRESSURE_EN = fc_enable_r && !FULL_DUPLEX;
    assign PAUSE_DECODE_EN = fc_enable_r && FULL_DUPLEX;
    assign RX_PAUSE_FILTER = RX_PAUSE_FRAME && PAUSE_DECODE_EN && fc_pass_r;

    ////////////////////////////////////////////////////////////////////
    // Tag comparators; zero tag field never extends the length
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            tag_a_r <= mfv_pkg::TAG_RESET;
            tag_b_r <= mfv_pkg::TAG_RESET;
        end else if (CE && wr) begin
            if (WB_ADR_I == mfv_pkg::TAG_A_OFS) begin
                if (WB_SEL_I[1]) tag_a_r[15:8] <= WB_DAT_I[15:8];
                if (WB_SEL_I[0]) tag_a_r[7:0] <= WB_DAT_I[7:0];
            end
            if (WB_ADR_I == mfv_pkg::TAG_B_OFS) begin
                if (WB_SEL_I[1]) tag_b_r[15:8] <= WB_DAT_I[15:8];
                if (WB_SEL_I[0]) tag_b_r[7:0] <= WB_DAT_I[7:0];
            end
        end
    end

    always_comb begin
        MAX_FRAME_LEN = mfv_pkg::LEN_BASE;
        if (RX_TAG_FIELD != 16'h0000 && RX_TAG_FIELD == tag_b_r) begin
            MAX_FRAME_LEN = mfv_pkg::LEN_TAG_B;
        end else if (RX_TAG_FIELD != 16'h0000
                     && RX_TAG_FIELD == tag_a_r) begin
            MAX_FRAME_LEN = mfv_pkg::LEN_TAG_A;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // PHY management handshake toward the serial engine
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mg_state_r <= mfv_pkg::MG_IDLE;
            mg_start_r <= 1'b0;
            mg_write_r <= 1'b0;
            mg_phy_r <= 5'h00;
            mg_reg_r <= 5'h00;
        end else if (CE) begin
            mg_start_r <= 1'b0;
            unique case (mg_state_r)
                mfv_pkg::MG_IDLE: begin
                    if (wr && WB_ADR_I == mfv_pkg::MGMT_ADDR_OFS) begin
                        mg_write_r <= WB_DAT_I[mfv_pkg::MA_WRITE_BIT];
                        mg_phy_r <= WB_DAT_I[mfv_pkg::MA_PHY_LSB +: 5];
                        mg_reg_r <= WB_DAT_I[mfv_pkg::MA_REG_LSB +: 5];
                        mg_start_r <= 1'b1;
                        mg_state_r <= mfv_pkg::MG_RUN;
                    end
                end
                mfv_pkg::MG_RUN: begin
                    if (MGMT_DONE) begin
                        mg_state_r <= mfv_pkg::MG_DONE;
                    end
                end
                mfv_pkg::MG_DONE: mg_state_r <= mfv_pkg::MG_IDLE;
                default: mg_state_r <= mfv_pkg::MG_IDLE;
            endcase
        end
    end

    // Engine read data overrides a same-cycle software write on read done
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            phy_word_r <= 16'h0000;
        end else if (CE) begin
            if (mg_state_r == mfv_pkg::MG_RUN && MGMT_DONE
                && !mg_write_r) begin
                phy_word_r <= MGMT_RDATA;
            end else if (wr && WB_ADR_I == mfv_pkg::PHY_DATA_OFS) begin
                if (WB_SEL_I[1]) phy_word_r[15:8] <= WB_DAT_I[15:8];
                if (WB_SEL_I[0]) phy_word_r[7:0] <= WB_DAT_I[7:0];
            end
        end
    end

    assign MGMT_START = mg_start_r;
    assign MGMT_WRITE = mg_write_r;
    assign MGMT_PHY_ADDR = mg_phy_r;
    assign MGMT_REG_ADDR = mg_reg_r;
    assign MGMT_WDATA = phy_word_r;

    ////////////////////////////////////////////////////////////////////
    // Wake filter window: pointer steps on every access
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            filt_ptr_r <= 3'h0;
        end else if (CE && req && WB_ADR_I == mfv_pkg::WAKE_PORT_OFS) begin
            filt_ptr_r <= filt_ptr_r + 3'h1;
        end
    end

    always_ff @(posedge CLK) begin
        if (CE && wr && WB_ADR_I == mfv_pkg::WAKE_PORT_OFS) begin
            filt_mem[filt_ptr_r] <= (filt_mem[filt_ptr_r] & ~wmask) | wd;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            filt_rd_r <= 32'h0000_0000;
        end else if (CE) begin
            filt_rd_r <= filt_mem[filt_ptr_r];
        end
    end

    assign FILTER_WORD = filt_rd_r;
    assign FILTER_INDEX = filt_ptr_r;

    ////////////////////////////////////////////////////////////////////
    // Wake control; flags live on power-on reset only
    assign frame_wake = wf_en_r && RX_WAKE_FRAME_MATCH
                        && (gu_r || RX_ADDR_PASS);
    assign pattern_wake = pp_en_r && RX_PATTERN_PACKET;

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            gu_r <= 1'b0;
            wf_en_r <= 1'b0;
            pp_en_r <= 1'b0;
        end else if (CE && wr && WB_ADR_I == mfv_pkg::WAKE_CTRL_OFS) begin
            if (WB_SEL_I[1]) gu_r <= WB_DAT_I[mfv_pkg::WK_GU_BIT];
            if (WB_SEL_I[0]) begin
                wf_en_r <= WB_DAT_I[mfv_pkg::WK_WF_EN_BIT];
                pp_en_r <= WB_DAT_I[mfv_pkg::WK_PP_EN_BIT];
            end
        end
    end

    // Set beats a same-cycle write-one clear
    always_ff @(posedge CLK or posedge POR_RST) begin
        if (POR_RST) begin
            wf_flag_r <= 1'b0;
            pp_flag_r <= 1'b0;
        end else if (CE) begin
            if (frame_wake) begin
                wf_flag_r <= 1'b1;
            end else if (wr && WB_ADR_I == mfv_pkg::WAKE_CTRL_OFS
                         && wd[mfv_pkg::WK_WF_FLAG_BIT]) begin
                wf_flag_r <= 1'b0;
            end
            if (pattern_wake) begin
                pp_flag_r <= 1'b1;
            end else if (wr && WB_ADR_I == mfv_pkg::WAKE_CTRL_OFS
                         && wd[mfv_pkg::WK_PP_FLAG_BIT]) begin
                pp_flag_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            wake_r <= 1'b0;
        end else if (CE) begin
            wake_r <= frame_wake || pattern_wake;
        end
    end

    assign SLEEP = wf_en_r || pp_en_r;
    assign WAKE_EVENT = wake_r;
endmodule
`default_nettype wire

// [mfv_csr_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module mfv_csr_chk #(
    parameter int FILTER_WORDS = 8
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CE,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic WB_ACK_O,
    input wire logic FULL_DUPLEX,
    input wire logic PAUSE_REQ,
    input wire logic [15:0] PAUSE_TIME,
    input wire logic PAUSE_SENT,
    input wire logic BACK_PRESSURE_EN,
    input wire logic PAUSE_DECODE_EN,
    input wire logic RX_PAUSE_FRAME,
    input wire logic RX_PAUSE_FILTER,
    input wire logic [15:0] RX_TAG_FIELD,
    input wire logic [10:0] MAX_FRAME_LEN,
    input wire logic MGMT_START,
    input wire logic RX_WAKE_FRAME_MATCH,
    input wire logic RX_PATTERN_PACKET,
    input wire logic WAKE_EVENT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && CE
        |=> WB_ACK_O) else $error("ack late");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack too long");
    a_pause_full: assert property (PAUSE_REQ |-> FULL_DUPLEX)
        else $error("pause in half duplex");
    a_pause_done: assert property (PAUSE_REQ && PAUSE_SENT
        |=> !PAUSE_REQ) else $error("busy kept after send");
    a_bp_half: assert property (BACK_PRESSURE_EN |-> !FULL_DUPLEX)
        else $error("back pressure in full duplex");
    a_decode_full: assert property (PAUSE_DECODE_EN |-> FULL_DUPLEX)
        else $error("decode in half duplex");
    a_filter_cause: assert property (RX_PAUSE_FILTER |-> RX_PAUSE_FRAME
        && PAUSE_DECODE_EN) else $error("filter bit without cause");
    a_len_notag: assert property (RX_TAG_FIELD == 16'h0
        |-> MAX_FRAME_LEN == mfv_pkg::LEN_BASE) else $error("zero tag length");
    a_wake_cause: assert property (WAKE_EVENT
        |-> $past(RX_WAKE_FRAME_MATCH || RX_PATTERN_PACKET))
        else $error("wake without cause");
    a_mgmt_start: assert property (MGMT_START
        |-> $past(WB_CYC_I && WB_STB_I && WB_WE_I
        && WB_ADR_I == mfv_pkg::MGMT_ADDR_OFS))
        else $error("start without write");
    a_ptime_hold: assert property ($changed(PAUSE_TIME)
        |-> $past(WB_WE_I && WB_ADR_I == mfv_pkg::FLOW_CTRL_OFS))
        else $error("pause time moved");
endmodule
bind mfv_csr mfv_csr_chk #(.FILTER_WORDS(FILTER_WORDS)) u_chk (.CLK(CLK),
    .SYS_RST(SYS_RST), .CE(CE), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_ACK_O(WB_ACK_O),
    .FULL_DUPLEX(FULL_DUPLEX), .PAUSE_REQ(PAUSE_REQ), .PAUSE_TIME(PAUSE_TIME),
    .PAUSE_SENT(PAUSE_SENT), .BACK_PRESSURE_EN(BACK_PRESSURE_EN),
    .PAUSE_DECODE_EN(PAUSE_DECODE_EN), .RX_PAUSE_FRAME(RX_PAUSE_FRAME),
    .RX_PAUSE_FILTER(RX_PAUSE_FILTER), .RX_TAG_FIELD(RX_TAG_FIELD),
    .MAX_FRAME_LEN(MAX_FRAME_LEN), .MGMT_START(MGMT_START),
    .RX_WAKE_FRAME_MATCH(RX_WAKE_FRAME_MATCH),
    .RX_PATTERN_PACKET(RX_PATTERN_PACKET), .WAKE_EVENT(WAKE_EVENT));
`default_nettype wire

// [mfv_csr_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module mfv_csr_tb;
    typedef struct {logic we; logic [7:0] a; logic [31:0] d;
        logic [31:0] q;} mfv_row_t;
    // Resets start low so the first assignment gives a real rising edge
    logic CLK = 1'b0, SYS_RST = 1'b0, POR_RST = 1'b0, CE = 1'b1;
    logic WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0, FULL_DUPLEX = 1'b0;
    logic [7:0] WB_ADR_I = 8'h0;
    logic [3:0] WB_SEL_I = 4'hf, lat = 4'h2;
    logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, FILTER_WORD;
    logic WB_ACK_O, PAUSE_REQ, PAUSE_SENT, BACK_PRESSURE_EN, PAUSE_DECODE_EN;
    logic RX_PAUSE_FILTER, MGMT_START, MGMT_WRITE, MGMT_DONE, SLEEP, WAKE_EVENT;
    logic RX_PAUSE_FRAME = 1'b0, RX_WAKE_FRAME_MATCH = 1'b0;
    logic RX_ADDR_PASS = 1'b0, RX_PATTERN_PACKET = 1'b0;
    logic [15:0] PAUSE_TIME, MGMT_WDATA, MGMT_RDATA, RX_TAG_FIELD = 16'h0;
    logic [10:0] MAX_FRAME_LEN;
    logic [4:0] MGMT_PHY_ADDR, MGMT_REG_ADDR;
    logic [2:0] FILTER_INDEX;
    int err_count = 0, n_compared = 0;
    mfv_row_t rows[11] = '{'{1'b0, 8'h1c, 32'h0, 32'h0},
        '{1'b0, 8'h20, 32'h0, 32'hffff}, '{1'b0, 8'h24, 32'h0, 32'hffff},
        '{1'b0, 8'h2c, 32'h0, 32'h0}, '{1'b0, 8'h18, 32'h0, 32'h0},
        '{1'b0, 8'h14, 32'h0, 32'h0}, '{1'b1, 8'h20, 32'hffff_8100, 32'h8100},
        '{1'b1, 8'h24, 32'h9100, 32'h9100}, '{1'b1, 8'h18, 32'hbeef, 32'hbeef},
        '{1'b1, 8'h1c, 32'h1234_0007, 32'h1234_0006},
        '{1'b1, 8'h30, 32'hdead_beef, 32'h0}};
    always #2 CLK = ~CLK;
    mfv_csr #(.FILTER_WORDS(8)) u_dut (.CLK(CLK), .SYS_RST(SYS_RST),
        .POR_RST(POR_RST), .CE(CE), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
        .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
        .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
        .FULL_DUPLEX(FULL_DUPLEX), .PAUSE_REQ(PAUSE_REQ),
        .PAUSE_TIME(PAUSE_TIME),
        .PAUSE_SENT(PAUSE_SENT), .BACK_PRESSURE_EN(BACK_PRESSURE_EN),
        .RX_PAUSE_FRAME(RX_PAUSE_FRAME), .PAUSE_DECODE_EN(PAUSE_DECODE_EN),
        .RX_PAUSE_FILTER(RX_PAUSE_FILTER), .RX_TAG_FIELD(RX_TAG_FIELD),
        .MAX_FRAME_LEN(MAX_FRAME_LEN), .MGMT_START(MGMT_START),
        .MGMT_WRITE(MGMT_WRITE), .MGMT_PHY_ADDR(MGMT_PHY_ADDR),
        .MGMT_REG_ADDR(MGMT_REG_ADDR), .MGMT_WDATA(MGMT_WDATA),
        .MGMT_DONE(MGMT_DONE), .MGMT_RDATA(MGMT_RDATA),
        .RX_WAKE_FRAME_MATCH(RX_WAKE_FRAME_MATCH), .RX_ADDR_PASS(RX_ADDR_PASS),
        .RX_PATTERN_PACKET(RX_PATTERN_PACKET), .FILTER_WORD(FILTER_WORD),
        .FILTER_INDEX(FILTER_INDEX), .SLEEP(SLEEP), .WAKE_EVENT(WAKE_EVENT));
    mfv_far_model u_far (.clk(CLK), .rst(SYS_RST), .lat(lat),
        .mgmt_start(MGMT_START), .mgmt_write(MGMT_WRITE), .pause_req(PAUSE_REQ),
        .mgmt_done(MGMT_DONE), .mgmt_rdata(MGMT_RDATA), .pause_sent(PAUSE_SENT));
    ////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        begin
            if (err_count == 0 && n_compared > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    // Classic cycle; request held until ack is sampled high
    task automatic wb(input logic [7:0] a, input logic we,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        begin
            n = 0;
            @(posedge CLK);
            WB_CYC_I <= 1'b1;
            WB_STB_I <= 1'b1;
            WB_WE_I <= we;
            WB_ADR_I <= a;
            WB_DAT_I <= d;
            do begin
                @(posedge CLK);
                n++;
            end while (WB_ACK_O !== 1'b1 && n < 20);
            q = WB_DAT_O;
            WB_CYC_I <= 1'b0;
            WB_STB_I <= 1'b0;
            if (n >= 20) begin
                err_count++;
                report_and_stop();
            end
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0, q);
        `CHK(q, e)
    endtask
    // Busy polls are bounded; a stuck bit ends the run
    task automatic poll(input logic [7:0] a);
        logic [31:0] q;
        int n;
        begin
            q = 32'h1;
            for (n = 0; n < 40 && q[0] !== 1'b0; n++)
                wb(a, 1'b0, 32'h0, q);
            `CHK(q[0], 1'b0)
            if (q[0] !== 1'b0)
                report_and_stop();
        end
    endtask
    task settle;
        begin
            @(posedge CLK);
            #1;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        SYS_RST <= 1'b1;
        POR_RST <= 1'b1;
        repeat (20) @(posedge CLK);
        SYS_RST <= 1'b0;
        POR_RST <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].we)
                wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].q);
        end
        RX_TAG_FIELD <= 16'h8100;
        settle();
        `CHK(MAX_FRAME_LEN, mfv_pkg::LEN_TAG_A)
        @(posedge CLK);
        RX_TAG_FIELD <= 16'h9100;
        settle();
        `CHK(MAX_FRAME_LEN, mfv_pkg::LEN_TAG_B)
        `CHK(BACK_PRESSURE_EN, 1'b1)
        `CHK(PAUSE_DECODE_EN, 1'b0)
        for (int i = 0; i < 8; i++)
            wr(8'h28, 32'ha5a5_0000 + i);
        settle();
        `CHK({FILTER_INDEX, FILTER_WORD}, {3'h0, 32'ha5a5_0000})
        for (int i = 0; i < 8; i++)
            rdc(8'h28, 32'ha5a5_0000 + i);
        wr(8'h14, 32'h1942);
        `CHK({MGMT_WRITE, MGMT_PHY_ADDR, MGMT_REG_ADDR}, 11'h465)
        `CHK(MGMT_WDATA, 16'hbeef)
        poll(8'h14);
        wr(8'h14, 32'h1940);
        poll(8'h14);
        rdc(8'h18, 32'h5a3c);
        lat <= 4'h9;
        FULL_DUPLEX <= 1'b1;
        RX_PAUSE_FRAME <= 1'b1;
        settle();
        `CHK(PAUSE_DECODE_EN, 1'b1)
        `CHK(RX_PAUSE_FILTER, 1'b1)
        wr(8'h1c, 32'h1234_0002);
        `CHK(RX_PAUSE_FILTER, 1'b0)
        wr(8'h1c, 32'h1234_0003);
        `CHK(PAUSE_REQ, 1'b1)
        `CHK(PAUSE_TIME, 16'h1234)
        poll(8'h1c);
        wr(8'h2c, 32'h4);
        `CHK(SLEEP, 1'b1)
        RX_WAKE_FRAME_MATCH <= 1'b1;
        rdc(8'h2c, 32'h4);
        RX_ADDR_PASS <= 1'b1;
        @(posedge CLK);
        RX_WAKE_FRAME_MATCH <= 1'b0;
        RX_ADDR_PASS <= 1'b0;
        rdc(8'h2c, 32'h44);
        wr(8'h2c, 32'h244);
        rdc(8'h2c, 32'h204);
        RX_WAKE_FRAME_MATCH <= 1'b1;
        @(posedge CLK);
        RX_WAKE_FRAME_MATCH <= 1'b0;
        rdc(8'h2c, 32'h244);
        wr(8'h2c, 32'h242);
        RX_PATTERN_PACKET <= 1'b1;
        @(posedge CLK);
        RX_PATTERN_PACKET <= 1'b0;
        #1;
        `CHK(WAKE_EVENT, 1'b1)
        rdc(8'h2c, 32'h222);
        // Ordinary reset must keep the flags, power-on must not
        SYS_RST <= 1'b1;
        repeat (2) @(posedge CLK);
        SYS_RST <= 1'b0;
        rdc(8'h2c, 32'h20);
        POR_RST <= 1'b1;
        repeat (2) @(posedge CLK);
        POR_RST <= 1'b0;
        rdc(8'h2c, 32'h0);
        // Clock enable low must freeze the wake pulse; the flag then sets once enable returns
        wr(8'h2c, 32'h2);
        CE <= 1'b0;
        RX_PATTERN_PACKET <= 1'b1;
        repeat (3) @(posedge CLK);
        CE <= 1'b1;
        #1;
        `CHK(WAKE_EVENT, 1'b0)
        rdc(8'h2c, 32'h22);
        RX_PATTERN_PACKET <= 1'b0;
        wr(8'h2c, 32'h22);
        rdc(8'h2c, 32'h2);
        report_and_stop();
    end
endmodule
`default_nettype wire

// [mfv_far_model.sv]
`timescale 1ns/10ps
`default_nettype none
module mfv_far_model #(
    parameter logic [15:0] RD_WORD = 16'h5a3c
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] lat,
    input wire logic mgmt_start,
    input wire logic mgmt_write,
    input wire logic pause_req,
    output logic mgmt_done,
    output logic [15:0] mgmt_rdata,
    output logic pause_sent
);
    logic [3:0] mcnt_r;
    logic [3:0] pcnt_r;
    logic wr_r;
    logic held_r;
    ////////////////////////////////////////////////////////////////////////
    // Serial engine stand-in; lat sets prompt or slow answers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mcnt_r <= 4'h0;
            wr_r <= 1'b0;
            mgmt_done <= 1'b0;
            mgmt_rdata <= 16'h0;
        end else begin
            mgmt_done <= (mcnt_r == 4'h1);
            // Data toggles outside done so stale words never look valid
            mgmt_rdata <= (mcnt_r == 4'h1 && !wr_r) ? RD_WORD
                : ~mgmt_rdata;
            if (mgmt_start) begin
                mcnt_r <= lat;
                wr_r <= mgmt_write;
            end else if (mcnt_r != 4'h0) begin
                mcnt_r <= mcnt_r - 4'h1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Transmitter stand-in; one pause frame per rising request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pcnt_r <= 4'h0;
            held_r <= 1'b0;
            pause_sent <= 1'b0;
        end else begin
            held_r <= pause_req;
            pause_sent <= (pcnt_r == 4'h1);
            if (pause_req && !held_r) begin
                pcnt_r <= lat;
            end else if (pcnt_r != 4'h0) begin
                pcnt_r <= pcnt_r - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [mfv_pkg.sv]
package mfv_pkg;
    // Register byte offsets
    localparam logic [7:0] MGMT_ADDR_OFS = 8'h14;
    localparam logic [7:0] PHY_DATA_OFS = 8'h18;
    localparam logic [7:0] FLOW_CTRL_OFS = 8'h1c;
    localparam logic [7:0] TAG_A_OFS = 8'h20;
    localparam logic [7:0] TAG_B_OFS = 8'h24;
    localparam logic [7:0] WAKE_PORT_OFS = 8'h28;
    localparam logic [7:0] WAKE_CTRL_OFS = 8'h2c;
    // Field positions
    localparam int FC_BUSY_BIT = 0;
    localparam int FC_ENABLE_BIT = 1;
    localparam int FC_PASS_BIT = 2;
    localparam int FC_PAUSE_LSB = 16;
    localparam int MA_BUSY_BIT = 0;
    localparam int MA_WRITE_BIT = 1;
    localparam int MA_REG_LSB = 6;
    localparam int MA_PHY_LSB = 11;
    localparam int WK_PP_EN_BIT = 1;
    localparam int WK_WF_EN_BIT = 2;
    localparam int WK_PP_FLAG_BIT = 5;
    localparam int WK_WF_FLAG_BIT = 6;
    localparam int WK_GU_BIT = 9;
    // Reset values
    localparam logic [15:0] TAG_RESET = 16'hffff;
    // Frame lengths
    localparam logic [10:0] LEN_BASE = 11'd1518;
    localparam logic [10:0] LEN_TAG_A = 11'd1522;
    localparam logic [10:0] LEN_TAG_B = 11'd1538;
    // Wake filter window depth
    localparam int WAKE_WORDS = 8;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    typedef enum logic [2:0] {
        MG_IDLE = 3'b001,
        MG_RUN = 3'b010,
        MG_DONE = 3'b100
    } mfv_mg_state_t;
endpackage
